// ===== sim/fch_properties.sv
// checker: answer framing on the command link
`timescale 1ns/1ps
`default_nettype none
module fch_properties (
  input wire logic clk, // clock
  input wire logic sys_rst, // reset
  input wire logic cmd_valid, // cmd
  input wire logic cmd_ready, // cmd
  input wire logic [7:0] cmd_data, // cmd
  input wire logic cmd_last, // cmd
  input wire logic rsp_valid, // answer
  input wire logic rsp_ready, // answer
  input wire logic [7:0] rsp_data, // answer
  input wire logic rsp_last // answer
);
  logic [7:0] typ_r, ci_r, ri_r;
  wire logic ct = cmd_valid && cmd_ready;
  wire logic rt = rsp_valid && rsp_ready;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // frame type and byte positions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ci_r <= 8'h00;
      ri_r <= 8'h00;
    end else begin
      if (ct) ci_r <= cmd_last ? 8'h00 : ci_r + 8'h01;
      if (ct && ci_r == 8'h00) typ_r <= cmd_data;
      if (rt) ri_r <= rsp_last ? 8'h00 : ri_r + 8'h01;
    end
  end
  sequence s_head; rsp_valid && ri_r == 8'h00; endsequence
  sequence s_stat; rsp_valid && ri_r == 8'h01; endsequence
  property p_hold; rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data); endproperty
  a_hold: assert property (p_hold) else $error("answer dropped");
  property p_busy; rsp_valid |-> !cmd_ready; endproperty
  a_busy: assert property (p_busy) else $error("cmd during answer");
  property p_head; s_head |-> rsp_data == (typ_r | 8'h80); endproperty
  a_head: assert property (p_head) else $error("bad answer type");
  property p_wd_lat;
    ct && cmd_last && ci_r == 8'h01 && typ_r == fch_pkg::T_WD |-> ##[1:2] rsp_valid;
  endproperty
  a_wd_lat: assert property (p_wd_lat) else $error("late answer");
  property p_wd; s_stat ##0 typ_r == fch_pkg::T_WD |-> rsp_data[7:1] == 7'h00 && rsp_last;
  endproperty
  a_wd: assert property (p_wd) else $error("bad wd status");
  property p_cfg; s_stat ##0 typ_r == fch_pkg::T_CFG |-> rsp_data[7:1] == 7'h00 && rsp_last;
  endproperty
  a_cfg: assert property (p_cfg) else $error("bad cfg status");
  property p_mid; s_stat ##0 typ_r == fch_pkg::T_MID |-> rsp_last; endproperty
  a_mid: assert property (p_mid) else $error("bad id length");
  property p_key; s_stat ##0 typ_r == fch_pkg::T_KEY |-> rsp_last == rsp_data[0]; endproperty
  a_key: assert property (p_key) else $error("bad key length");
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// bench: frames from the wishbone host end to the device end
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, sys_rst, cyc, stb, we, ack, kp, kerr, lsc, srl, key_rd, wd_cfg, kflt;
  logic [11:0] adr;
  logic [31:0] dw, dr, rd;
  logic [3:0] sel;
  logic [15:0] fin, sos, fout;
  logic [6:0] kad;
  logic [7:0] kdat = 8'h00;
  logic [7:0] wd_ms, len, e1, e2;
  logic [7:0] tx[48];
  logic [39:0] rows[4] = '{40'h3a0502000a, 40'h3ac8020164, 40'h3a32020132, 40'h3c00015a32};
  int err_total, checked, n;
  fch_link_if link();
  fch_host u_fch_host (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
    .wb_ack_o(ack), .link(link));
  fch_device #(.TB_CYC(50)) u_fch_device (.clk(clk), .sys_rst(sys_rst), .link(link),
    .line_sync_clock(lsc), .system_reset_low(srl), .field_in(fin), .set_out_state(sos),
    .field_out(fout), .key_present(kp), .key_rd(key_rd), .key_addr(kad), .key_data(kdat),
    .key_err(kerr), .wd_timeout_ms(wd_ms), .wd_configured(wd_cfg), .key_fault(kflt));
  fch_properties u_chk (.clk(clk), .sys_rst(sys_rst), .cmd_valid(link.cmd_valid),
    .cmd_ready(link.cmd_ready), .cmd_data(link.cmd_data), .cmd_last(link.cmd_last),
    .rsp_valid(link.rsp_valid), .rsp_ready(link.rsp_ready), .rsp_data(link.rsp_data),
    .rsp_last(link.rsp_last));
  // key memory: byte j holds j
  always @(posedge clk) kdat <= {1'b0, kad};
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (err_total == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    {cyc, stb, we, adr, dw} <= {2'b11, w, a, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 50);
    rd = dr;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
    if (k == 50) begin
      err_total++;
      finish_test();
    end
  endtask
  // send tx frame of l bytes, poll until done
  task automatic run(input int l);
    for (int j = 0; j < l; j++) wb(1'b1, 12'(12'h200 + 4 * j), {24'h0, tx[j]});
    wb(1'b1, 12'h004, 32'(l));
    wb(1'b1, 12'h000, 32'h1);
    n = 0;
    do begin
      wb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[1] !== 1'b1 && n < 400);
    if (n == 400) begin
      err_total++;
      finish_test();
    end
  endtask
  task automatic ans(input logic [7:0] h, s, l);
    wb(1'b0, 12'h400, 32'h0);
    chk("head", rd, h);
    wb(1'b0, 12'h404, 32'h0);
    chk("status", rd, s);
    wb(1'b0, 12'h008, 32'h0);
    chk("rxlen", rd, l);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {cyc, stb, we, kerr, lsc, kp, adr, dw, fin, err_total, checked} = '0;
    {sys_rst, srl, sel, sos} = {2'b11, 4'h1, 16'h00a5};
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk("wd reset", wd_ms, 8'h64);
    chk("key fault", kflt, 1'b1);
    foreach (rows[r]) begin
      {tx[0], tx[1], len, e1, e2} = rows[r];
      run(len);
      ans(tx[0] | 8'h80, e1, 8'h02);
      chk("timeout", wd_ms, e2);
    end
    chk("wd set", wd_cfg, 1'b1);
    tx[0] = 8'h3b;
    run(1);
    ans(8'hbb, 8'h01, 8'h02);
    kp <= 1'b1;
    repeat (5) @(posedge clk);
    run(1);
    ans(8'hbb, 8'h00, 8'h82);
    wb(1'b0, 12'h604, 32'h0);
    chk("key byte", rd, 32'h7f);
    {tx[0], tx[1]} = 16'h3d00;
    run(2);
    ans(8'hbd, 8'h00, 8'h02);
    // nine enabling items, then eight plus one bad output number
    for (int j = 0; j < 9; j++)
      {tx[2 + 5 * j], tx[3 + 5 * j], tx[4 + 5 * j], tx[5 + 5 * j], tx[6 + 5 * j]} =
        {8'h80 | j[7:0], j[7:0], 24'h000101};
    tx[1] = 8'h09;
    run(47);
    ans(8'hbd, 8'h01, 8'h02);
    tx[42] = 8'h94;
    run(47);
    ans(8'hbd, 8'h00, 8'h02);
    {e1, e2} = '0;
    repeat (120) begin
      @(posedge clk);
      {e1, e2} = {e1 | fout[7:0], e2 | ~fout[7:0]};
    end
    chk("oscillate", e1 & e2, 8'hff);
    {tx[0], tx[1]} = 16'h3d00;
    run(2);
    chk("disabled", fout, sos);
    tx[0] = 8'h3a;
    run(1);
    chk("refused", rd[2], 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire

// ===== src/fch_device.sv
// field io module end: command decode, complex outputs, watchdog, key
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RULE1] tick source bit picks line sync or time base
// [RULE2] config answer flags overflow, else clears it
// [RULE3] item count 0..16; zero disables all functions
// [RULE4] controlling inputs sampled every clock cycle
// [RULE5] over eight enabled: apply nothing, flag overflow
// [RULE6] invalid item skipped, uncounted, rest processed
// [RULE7] disabled output follows latest output state
// [RULE8] replaced function keeps present output level
// [RULE9] gating overrides triggering
// [RULE10] gated oscillation stopping forces output low
// [RULE11] single pulse end disables, restores output state
// [RULE12] watchdog command 58, answer 186 with status
// [RULE13] timeout in ms clamped to 10..100
// [RULE14] status tells whether timeout was set before
// [RULE15] identification 59 answered 187 with key bytes
// [RULE16] key presence tested at reset release, readout
// [RULE17] key fault cuts answer to two bytes
// [RULE18] module identification 60 answered 188 with value
// [RULE19] single pulse once, else continuous oscillation
// [RULE20] outputs start within 2 ms
// [RULE21] gated output runs only while input active
// [RULE22] answer only after command fully processed
module fch_device #(
  parameter int TB_CYC = fch_pkg::TB_CYC, // time base period in cycles
  parameter logic [7:0] MODULE_ID = fch_pkg::MODULE_ID_DEF // arbitrary id
) (
  input wire logic clk, // 50 MHz clock
  input wire logic sys_rst, // sync reset, active high
  fch_link_if.dev link, // command and response link
  input wire logic line_sync_clock, // line synchronised clock pin
  input wire logic system_reset_low, // system reset pin
  input wire logic [fch_pkg::NUM_IN-1:0] field_in, // field input pins
  input wire logic [fch_pkg::NUM_OUT-1:0] set_out_state, // latest output state
  output logic [fch_pkg::NUM_OUT-1:0] field_out, // output levels
  input wire logic key_present, // key presence pin
  output logic key_rd, // key memory read strobe
  output logic [6:0] key_addr, // key memory address
  input wire logic [7:0] key_data, // key data, cycle after read
  input wire logic key_err, // key read error, with data
  output logic [7:0] wd_timeout_ms, // watchdog timeout
  output logic wd_configured, // timeout set at least once
  output logic key_fault // key fault flag
);
  localparam int NO = fch_pkg::NUM_OUT;
  localparam int NI = fch_pkg::NUM_IN;
  localparam int SW = NI + 3;
  logic [SW-1:0] s1_r, s2_r;
  logic [NI-1:0] in_s;
  logic kp_s, srl_s, ls_s, srl_d_r, ls_d_r, tb_tick, tick;
  logic [15:0] tb_cnt_r;
  fch_pkg::fch_dst_t st_r;
  logic [7:0] cmd_type_r, b0_r, b1_r, b2_r, b3_r, rsp_idx_r, rsp_data_r;
  logic [7:0] nidx, nxt_byte, last_idx;
  logic [2:0] bpos_r;
  logic [4:0] item_cnt_r, items_r, en_cnt;
  logic hdr_seen_r, tick_sel_r, tick_new_r, v_r, wd_prev_r, wd_got_r;
  logic hs_in, item_apply, it_ok, commit_ok, zero_all, k_issue_r, rd_d_r;
  logic [6:0] k_addr_r, k_cap_r;
  logic [7:0] key_buf [0:fch_pkg::KEY_BYTES-1];
  fch_pkg::fch_cfg_t cfg_r [0:NO-1];
  fch_pkg::fch_cfg_t shd_r [0:NO-1];
  fch_pkg::fch_cfg_t it;
  logic [NO-1:0] touch_r, start_r, en_new;
  wire [NO-1:0] eng_done;
  wire [NO-1:0] eng_lvl;

  // two-stage synchronisers for every pin input
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= {line_sync_clock, system_reset_low, key_present, field_in}; // [RULE4]
      s2_r <= s1_r;
    end
  end
  assign in_s = s2_r[NI-1:0];
  assign kp_s = s2_r[NI];
  assign srl_s = s2_r[NI+1];
  assign ls_s = s2_r[NI+2];

  // edge history and module time base
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      srl_d_r <= 1'b0;
      ls_d_r <= 1'b0;
      tb_cnt_r <= '0;
    end else begin
      srl_d_r <= srl_s;
      ls_d_r <= ls_s;
      tb_cnt_r <= tb_tick ? 16'h0000 : tb_cnt_r + 16'h0001;
    end
  end
  assign tb_tick = (tb_cnt_r == 16'(TB_CYC - 1));
  assign tick = tick_sel_r ? (ls_s & ~ls_d_r) : tb_tick; // [RULE1]

  // link handshake outputs
  assign hs_in = link.cmd_valid & link.cmd_ready;
  assign link.cmd_ready = (st_r == fch_pkg::D_IDLE) || (st_r == fch_pkg::D_CFG) ||
                          (st_r == fch_pkg::D_WD) || (st_r == fch_pkg::D_DRAIN);
  assign link.rsp_valid = (st_r == fch_pkg::D_SEND); // [RULE22]
  assign link.rsp_data = rsp_data_r;
  assign link.rsp_last = (rsp_idx_r == last_idx);
  assign last_idx = (cmd_type_r == fch_pkg::T_KEY && !key_fault) ?
                    8'(fch_pkg::KEY_BYTES + 1) : 8'h01; // [RULE15] [RULE17]
  assign key_rd = (st_r == fch_pkg::D_KREAD) && k_issue_r;
  assign key_addr = k_addr_r;
  assign field_out = eng_lvl;

  // current item as it will be stored; gating clears triggering
  always_comb begin
    it = '0;
    it.en = b0_r[fch_pkg::B0_EN];
    it.j = b1_r[fch_pkg::B1_J];
    it.inp = b1_r[6:0];
    it.r = b2_r[fch_pkg::B2_R];
    it.p = b2_r[fch_pkg::B2_P];
    it.g = b2_r[fch_pkg::B2_G];
    it.w = b2_r[fch_pkg::B2_W] & ~b2_r[fch_pkg::B2_G]; // [RULE9]
    it.prim = b3_r;
    it.sec = link.cmd_data;
  end
  assign it_ok = (b0_r[6:0] < 7'(NO)) && (!(it.g | it.w) || b1_r[6:0] < 7'(NI)); // [RULE6]
  assign item_apply = (st_r == fch_pkg::D_CFG) && hs_in && hdr_seen_r && bpos_r == 3'h4 &&
                      items_r < item_cnt_r && items_r < 5'(fch_pkg::MAX_ITEMS) && it_ok;

  // count of functions enabled if the staged items were applied
  always_comb begin
    en_cnt = '0;
    for (int i = 0; i < NO; i++) begin
      en_new[i] = touch_r[i] ? shd_r[i].en : cfg_r[i].en;
      en_cnt = en_cnt + 5'(en_new[i]);
    end
  end
  assign zero_all = (item_cnt_r == 5'h00);
  assign commit_ok = zero_all || en_cnt <= 5'(fch_pkg::MAX_EN); // [RULE5]

  // live and staged complex output configuration
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < NO; i++) begin
        cfg_r[i] <= '0;
        shd_r[i] <= '0;
      end
      touch_r <= '0;
      start_r <= '0;
    end else begin
      start_r <= '0;
      for (int i = 0; i < NO; i++) begin
        if (eng_done[i]) begin
          cfg_r[i].en <= 1'b0; // [RULE11]
        end
      end
      if (st_r == fch_pkg::D_IDLE) begin
        touch_r <= '0;
      end
      if (item_apply) begin
        shd_r[b0_r[3:0]] <= it;
        touch_r[b0_r[3:0]] <= 1'b1;
      end
      if (st_r == fch_pkg::D_COMMIT && zero_all) begin
        for (int i = 0; i < NO; i++) begin
          cfg_r[i].en <= 1'b0; // [RULE3]
        end
      end else if (st_r == fch_pkg::D_COMMIT && commit_ok) begin
        for (int i = 0; i < NO; i++) begin
          if (touch_r[i]) begin
            cfg_r[i] <= shd_r[i];
          end
        end
        start_r <= touch_r & en_new; // [RULE20]
      end
    end
  end

  // watchdog timeout load with clamping
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wd_timeout_ms <= fch_pkg::WD_RST_MS;
      wd_configured <= 1'b0;
      wd_prev_r <= 1'b0;
    end else if (st_r == fch_pkg::D_WD && hs_in && !wd_got_r) begin
      wd_prev_r <= wd_configured; // [RULE14]
      wd_configured <= 1'b1;
      if (link.cmd_data < fch_pkg::WD_MIN_MS) begin
        wd_timeout_ms <= fch_pkg::WD_MIN_MS; // [RULE13]
      end else if (link.cmd_data > fch_pkg::WD_MAX_MS) begin
        wd_timeout_ms <= fch_pkg::WD_MAX_MS; // [RULE13]
      end else begin
        wd_timeout_ms <= link.cmd_data;
      end
    end
  end

  // key fault: presence tests, read errors win over a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      key_fault <= 1'b0;
    end else begin
      if ((srl_s && !srl_d_r) || st_r == fch_pkg::D_KTEST) begin
        key_fault <= ~kp_s; // [RULE16]
      end
      if (st_r == fch_pkg::D_KREAD && rd_d_r && key_err) begin
        key_fault <= 1'b1; // [RULE17]
      end
    end
  end

  // next response byte after the current one
  always_comb begin
    nidx = rsp_idx_r + 8'h01;
    nxt_byte = key_buf[7'(nidx - 8'h02)];
    if (nidx == 8'h01) begin
      case (cmd_type_r)
        fch_pkg::T_WD: nxt_byte = {7'h00, wd_prev_r}; // [RULE12]
        fch_pkg::T_KEY: nxt_byte = {7'h00, key_fault}; // [RULE15]
        fch_pkg::T_MID: nxt_byte = MODULE_ID; // [RULE18]
        fch_pkg::T_CFG: nxt_byte = {7'h00, v_r}; // [RULE2]
        default: nxt_byte = 8'h00;
      endcase
    end
  end

  // frame decode, key readout and response sequencing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= fch_pkg::D_IDLE;
      cmd_type_r <= 8'h00;
      {b0_r, b1_r, b2_r, b3_r} <= '0;
      {bpos_r, item_cnt_r, items_r} <= '0;
      {hdr_seen_r, tick_sel_r, tick_new_r, v_r, wd_got_r} <= '0;
      {k_addr_r, k_cap_r, k_issue_r, rd_d_r} <= '0;
      rsp_idx_r <= 8'h00;
      rsp_data_r <= 8'h00;
    end else begin
      rd_d_r <= key_rd;
      if (st_r != fch_pkg::D_SEND) begin
        rsp_idx_r <= 8'h00;
        rsp_data_r <= (st_r == fch_pkg::D_IDLE ? link.cmd_data : cmd_type_r) | fch_pkg::RSP_BIT;
      end
      case (st_r)
        fch_pkg::D_IDLE: begin
          if (hs_in) begin
            cmd_type_r <= link.cmd_data;
            {hdr_seen_r, wd_got_r, bpos_r, items_r} <= '0;
            case (link.cmd_data)
              fch_pkg::T_CFG: st_r <= link.cmd_last ? fch_pkg::D_IDLE : fch_pkg::D_CFG;
              fch_pkg::T_WD: st_r <= link.cmd_last ? fch_pkg::D_IDLE : fch_pkg::D_WD;
              fch_pkg::T_KEY: st_r <= link.cmd_last ? fch_pkg::D_KTEST : fch_pkg::D_DRAIN;
              fch_pkg::T_MID: st_r <= link.cmd_last ? fch_pkg::D_SEND : fch_pkg::D_DRAIN;
              default: st_r <= link.cmd_last ? fch_pkg::D_IDLE : fch_pkg::D_DRAIN;
            endcase
          end
        end
        fch_pkg::D_CFG: begin
          if (hs_in) begin
            if (!hdr_seen_r) begin
              hdr_seen_r <= 1'b1;
              tick_new_r <= link.cmd_data[fch_pkg::HDR_L];
              item_cnt_r <= link.cmd_data[4:0];
            end else begin
              case (bpos_r)
                3'h0: b0_r <= link.cmd_data;
                3'h1: b1_r <= link.cmd_data;
                3'h2: b2_r <= link.cmd_data;
                3'h3: b3_r <= link.cmd_data;
                default: b3_r <= b3_r;
              endcase
              bpos_r <= (bpos_r == 3'h4) ? 3'h0 : bpos_r + 3'h1;
              if (bpos_r == 3'h4 && items_r < 5'(fch_pkg::MAX_ITEMS)) begin
                items_r <= items_r + 5'h01;
              end
            end
            if (link.cmd_last) begin
              st_r <= fch_pkg::D_COMMIT;
            end
          end
        end
        fch_pkg::D_COMMIT: begin
          v_r <= ~commit_ok; // [RULE2]
          if (commit_ok) begin
            tick_sel_r <= tick_new_r; // [RULE1]
          end
          st_r <= fch_pkg::D_SEND;
        end
        fch_pkg::D_WD: begin
          if (hs_in) begin
            wd_got_r <= 1'b1;
            if (link.cmd_last) begin
              st_r <= fch_pkg::D_SEND; // [RULE22]
            end
          end
        end
        fch_pkg::D_DRAIN: begin
          if (hs_in && link.cmd_last) begin
            st_r <= fch_pkg::D_IDLE;
          end
        end
        fch_pkg::D_KTEST: begin
          k_addr_r <= 7'h00;
          k_cap_r <= 7'h00;
          k_issue_r <= kp_s;
          st_r <= kp_s ? fch_pkg::D_KREAD : fch_pkg::D_SEND; // [RULE16]
        end
        fch_pkg::D_KREAD: begin
          if (k_issue_r) begin
            k_addr_r <= k_addr_r + 7'h01;
            k_issue_r <= (k_addr_r != 7'h7f);
          end
          if (rd_d_r) begin
            key_buf[k_cap_r] <= key_data;
            k_cap_r <= k_cap_r + 7'h01;
            if (k_cap_r == 7'h7f) begin
              st_r <= fch_pkg::D_SEND; // [RULE22]
            end
          end
        end
        fch_pkg::D_SEND: begin
          if (link.rsp_ready) begin
            rsp_idx_r <= nidx;
            rsp_data_r <= nxt_byte;
            if (link.rsp_last) begin
              st_r <= fch_pkg::D_IDLE;
            end
          end
        end
        default: st_r <= fch_pkg::D_IDLE;
      endcase
    end
  end

  // one complex output engine per output
  for (genvar gi = 0; gi < NO; gi++) begin : g_eng
    fch_pkg::fch_cfg_t c;
    fch_pkg::fch_ph_t ph_r;
    logic [7:0] cnt_r, dur;
    logic lvl_r, act, act_d_r, done_r, cnt_end;
    assign c = cfg_r[gi];
    assign act = in_s[c.inp[3:0]] ^ c.r; // [RULE4]
    assign dur = (ph_r == fch_pkg::P_PRIM) ? c.prim : c.sec;
    assign cnt_end = ({1'b0, cnt_r} + 9'h001) >= {1'b0, dur};
    assign eng_done[gi] = done_r;
    assign eng_lvl[gi] = lvl_r;
    always_ff @(posedge clk) begin
      done_r <= 1'b0;
      act_d_r <= act;
      if (sys_rst) begin
        ph_r <= fch_pkg::P_WAIT;
        cnt_r <= 8'h00;
        lvl_r <= 1'b0;
        act_d_r <= 1'b0;
      end else if (!c.en) begin
        ph_r <= fch_pkg::P_WAIT;
        lvl_r <= set_out_state[gi]; // [RULE7] [RULE11]
      end else if (start_r[gi]) begin
        ph_r <= (c.g | c.w) ? fch_pkg::P_WAIT : fch_pkg::P_PRIM; // [RULE8] [RULE20]
        cnt_r <= 8'h00;
        act_d_r <= 1'b0;
      end else if (c.g && !act) begin
        ph_r <= fch_pkg::P_WAIT; // [RULE21]
        cnt_r <= 8'h00;
        if (!c.p) begin
          lvl_r <= 1'b0; // [RULE10]
        end
      end else if (ph_r == fch_pkg::P_WAIT) begin
        if (c.g || (act && !act_d_r)) begin
          ph_r <= fch_pkg::P_PRIM; // [RULE9] [RULE20]
        end
      end else if (tick) begin
        cnt_r <= cnt_r + 8'h01;
        if (ph_r == fch_pkg::P_PRIM) begin
          lvl_r <= c.j;
          if (cnt_end) begin
            ph_r <= fch_pkg::P_SEC;
            cnt_r <= 8'h00;
          end
        end else begin
          lvl_r <= ~c.j;
          if (c.sec != 8'h00 && cnt_end) begin
            cnt_r <= 8'h00;
            if (c.p) begin
              done_r <= 1'b1; // [RULE19] [RULE11]
            end else begin
              ph_r <= fch_pkg::P_PRIM; // [RULE19]
            end
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/fch_host.sv
// controller cpu end: wishbone registers drive command frames
`timescale 1ns/1ps
`default_nettype none
module fch_host (
  input wire logic clk, // 50 MHz clock
  input wire logic sys_rst, // sync reset, active high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [11:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  fch_link_if.host link // command and response link
);
  fch_pkg::fch_hst_t st_r;
  logic [7:0] tx_mem [0:fch_pkg::TX_MAX-1];
  logic [7:0] rx_mem [0:fch_pkg::RX_MAX-1];
  logic [7:0] tx_len_r, rx_len_r, tx_idx_r, cmd_data_r, t0, first, nlen;
  logic done_r, err_r, req, wr, go, bad, rsp_bad;
  logic [7:0] ridx;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  assign go = wr && wb_adr_i[11:9] == fch_pkg::HA_REGS && wb_adr_i[3:2] == fch_pkg::HR_CTRL &&
              wb_dat_i[0] && st_r == fch_pkg::H_IDLE;
  assign ridx = wb_adr_i[9:2];
  assign t0 = tx_mem[0];

  // frames the far end must not be sent
  assign bad = tx_len_r == 8'h00 ||
               (t0 == fch_pkg::T_WD && tx_len_r != 8'h02) || // [RULE12]
               ((t0 == fch_pkg::T_KEY || t0 == fch_pkg::T_MID) && tx_len_r != 8'h01) ||
               (t0 == fch_pkg::T_CFG && (tx_len_r < 8'h02 ||
                tx_mem[1][4:0] > 5'(fch_pkg::MAX_ITEMS))); // [RULE3]

  // answer type and length check on the final byte
  assign first = (rx_len_r == 8'h00) ? link.rsp_data : rx_mem[0];
  assign nlen = rx_len_r + 8'h01;
  assign rsp_bad = first != (t0 | fch_pkg::RSP_BIT) ||
                   (t0 == fch_pkg::T_KEY ? (nlen != 8'h02 && nlen != 8'(fch_pkg::RX_MAX))
                                         : nlen != 8'h02); // [RULE15] [RULE18]

  assign link.cmd_valid = (st_r == fch_pkg::H_TX);
  assign link.cmd_data = cmd_data_r;
  assign link.cmd_last = (tx_idx_r == tx_len_r - 8'h01);
  assign link.rsp_ready = (st_r == fch_pkg::H_RX);

  // wishbone acknowledge and read data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        case (wb_adr_i[11:9])
          fch_pkg::HA_REGS: begin
            case (wb_adr_i[3:2])
              fch_pkg::HR_CTRL: wb_dat_o <= {29'h0, err_r, done_r, st_r != fch_pkg::H_IDLE};
              fch_pkg::HR_TXLEN: wb_dat_o <= {24'h0, tx_len_r};
              fch_pkg::HR_RXLEN: wb_dat_o <= {24'h0, rx_len_r};
              default: wb_dat_o <= 32'h0000_0000;
            endcase
          end
          fch_pkg::HA_TX: wb_dat_o <= {24'h0, tx_mem[wb_adr_i[8:2]]};
          3'h2, 3'h3: begin
            if (ridx < 8'(fch_pkg::RX_MAX)) begin
              wb_dat_o <= {24'h0, rx_mem[ridx]};
            end
          end
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // frame buffer and length writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_len_r <= 8'h00;
    end else if (wr && st_r == fch_pkg::H_IDLE) begin
      if (wb_adr_i[11:9] == fch_pkg::HA_TX) begin
        tx_mem[wb_adr_i[8:2]] <= wb_dat_i[7:0];
      end else if (wb_adr_i[11:9] == fch_pkg::HA_REGS && wb_adr_i[3:2] == fch_pkg::HR_TXLEN) begin
        tx_len_r <= wb_dat_i[7:0];
      end
    end
  end

  // send the frame, collect the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= fch_pkg::H_IDLE;
      {tx_idx_r, rx_len_r, cmd_data_r} <= '0;
      {done_r, err_r} <= 2'b00;
    end else begin
      case (st_r)
        fch_pkg::H_IDLE: begin
          if (go) begin
            done_r <= bad;
            err_r <= bad;
            tx_idx_r <= 8'h00;
            rx_len_r <= 8'h00;
            cmd_data_r <= t0;
            st_r <= bad ? fch_pkg::H_IDLE : fch_pkg::H_TX;
          end
        end
        fch_pkg::H_TX: begin
          if (link.cmd_ready) begin
            tx_idx_r <= tx_idx_r + 8'h01;
            cmd_data_r <= tx_mem[7'(tx_idx_r + 8'h01)];
            if (link.cmd_last) begin
              st_r <= fch_pkg::H_RX;
            end
          end
        end
        fch_pkg::H_RX: begin
          if (link.rsp_valid) begin
            if (rx_len_r < 8'(fch_pkg::RX_MAX)) begin
              rx_mem[rx_len_r] <= link.rsp_data;
              rx_len_r <= nlen;
            end
            if (link.rsp_last) begin
              done_r <= 1'b1;
              err_r <= rsp_bad;
              st_r <= fch_pkg::H_IDLE;
            end
          end
        end
        default: st_r <= fch_pkg::H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== src/fch_link_if.sv
// byte link between controller cpu end and field io module end
`timescale 1ns/1ps
`default_nettype none
interface fch_link_if;
  logic cmd_valid;
  logic cmd_ready;
  logic [7:0] cmd_data;
  logic cmd_last;
  logic rsp_valid;
  logic rsp_ready;
  logic [7:0] rsp_data;
  logic rsp_last;
  modport dev (
    input cmd_valid, cmd_data, cmd_last, rsp_ready,
    output cmd_ready, rsp_valid, rsp_data, rsp_last
  );
  modport host (
    output cmd_valid, cmd_data, cmd_last, rsp_ready,
    input cmd_ready, rsp_valid, rsp_data, rsp_last
  );
endinterface
`default_nettype wire

// ===== src/fch_pkg.sv
// shared constants, types and encodings of the field io command handler
package fch_pkg;
  localparam int CLK_KHZ = 50000;
  localparam int TB_MS = 1;
  localparam int TB_CYC = TB_MS * CLK_KHZ;
  localparam int NUM_OUT = 16;
  localparam int NUM_IN = 16;
  localparam int MAX_EN = 8;
  localparam int MAX_ITEMS = 16;
  localparam int KEY_BYTES = 128;
  localparam int RX_MAX = KEY_BYTES + 2;
  localparam int TX_MAX = 128;
  // frame types; an answer is the command type with the top bit set
  localparam logic [7:0] T_CFG = 8'h3d;
  localparam logic [7:0] T_WD = 8'h3a;
  localparam logic [7:0] T_KEY = 8'h3b;
  localparam logic [7:0] T_MID = 8'h3c;
  localparam logic [7:0] RSP_BIT = 8'h80;
  localparam logic [7:0] WD_MIN_MS = 8'h0a;
  localparam logic [7:0] WD_MAX_MS = 8'h64;
  localparam logic [7:0] WD_RST_MS = 8'h64;
  localparam logic [7:0] MODULE_ID_DEF = 8'h5a; // arbitrary value
  // field positions in config header and item bytes
  localparam int HDR_L = 7;
  localparam int B0_EN = 7;
  localparam int B1_J = 7;
  localparam int B2_R = 6;
  localparam int B2_P = 5;
  localparam int B2_W = 4;
  localparam int B2_G = 3;
  // host register word indices and address areas
  localparam logic [2:0] HA_REGS = 3'h0;
  localparam logic [2:0] HA_TX = 3'h1;
  localparam logic [1:0] HR_CTRL = 2'h0;
  localparam logic [1:0] HR_TXLEN = 2'h1;
  localparam logic [1:0] HR_RXLEN = 2'h2;
  typedef struct packed {
    logic en;
    logic j;
    logic p;
    logic w;
    logic g;
    logic r;
    logic [6:0] inp;
    logic [7:0] prim;
    logic [7:0] sec;
  } fch_cfg_t;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_CFG = 3'b001, D_COMMIT = 3'b011, D_SEND = 3'b010,
    D_KTEST = 3'b110, D_KREAD = 3'b111, D_WD = 3'b101, D_DRAIN = 3'b100
  } fch_dst_t;
  typedef enum logic [1:0] {P_WAIT = 2'b00, P_PRIM = 2'b01, P_SEC = 2'b11} fch_ph_t;
  typedef enum logic [1:0] {H_IDLE = 2'b00, H_TX = 2'b01, H_RX = 2'b11} fch_hst_t;
endpackage
